// File: core/audio_level_pkg.sv
// package: register map, field layouts and carrier types of the audio level block
package audio_level_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] FMT_IDX = 8'h02;
  localparam logic [7:0] CFG_IDX = 8'h03;
  localparam logic [7:0] LEFT_IDX = 8'h04;
  localparam logic [7:0] RIGHT_IDX = 8'h05;
  localparam logic [7:0] STAT_IDX = 8'h18;
  // field positions
  localparam int FADE_BIT = 7;
  localparam int MUTE_R_BIT = 1;
  localparam int MUTE_L_BIT = 0;
  localparam int FMT_W = 6;
  // level codes
  localparam logic [7:0] LEVEL_RESET = 8'hCF;
  localparam logic [7:0] LEVEL_MIN = 8'h07;
  localparam logic [7:0] LEVEL_TOP = 8'hFF;
  localparam logic [7:0] LEVEL_OFF = 8'h00;
  localparam logic [7:0] STEPS_PER_6DB = 8'h0C;
  // sample path
  localparam int SAMPLE_W = 24;
  localparam logic [4:0] WORD_BITS = 5'h18;
  localparam int GAIN_SHIFT = 11;
  localparam logic signed [43:0] SAT_POS = 44'sh0000007FFFFF;
  localparam logic signed [43:0] SAT_NEG = -44'sh000000800000;
  localparam logic [23:0] SAMPLE_MAX = 24'h7FFFFF;
  localparam logic [23:0] SAMPLE_MIN = 24'h800000;

  typedef enum logic [2:0] {
    FMT_RJ24 = 3'h0, FMT_RJ20 = 3'h1, FMT_RJ18 = 3'h2,
    FMT_RJ16 = 3'h3, FMT_I2S = 3'h4, FMT_LJ = 3'h5
  } fmt_t;

  typedef struct packed {logic [1:0] boost; logic speed; logic [2:0] fmt;} path_fmt_t;
  typedef struct packed {logic fade; logic mute_r; logic mute_l;} level_cfg_t;
  typedef struct packed {logic sck; logic lrck; logic sdin;} serial_in_t;
  typedef struct packed {
    logic valid; logic [23:0] left; logic [23:0] right; logic mute_l; logic mute_r;
  } audio_out_t;

  localparam path_fmt_t FMT_RESET = '{boost: 2'h1, speed: 1'b0, fmt: 3'h4};
  localparam level_cfg_t CFG_RESET = '{fade: 1'b1, mute_r: 1'b0, mute_l: 1'b0};

  // 2^(-r/12) in Q15, one entry per half-dB step inside a 6 dB octave
  function automatic logic [15:0] step_mant(input logic [3:0] r);
    case (r)
      4'h0: step_mant = 16'h8000;
      4'h1: step_mant = 16'h78D1;
      4'h2: step_mant = 16'h7209;
      4'h3: step_mant = 16'h6BA2;
      4'h4: step_mant = 16'h6598;
      4'h5: step_mant = 16'h5FE4;
      4'h6: step_mant = 16'h5A82;
      4'h7: step_mant = 16'h556E;
      4'h8: step_mant = 16'h50A3;
      4'h9: step_mant = 16'h4C1C;
      4'hA: step_mant = 16'h47D6;
      default: step_mant = 16'h43CE;
    endcase
  endfunction : step_mant
endpackage : audio_level_pkg

// File: core/audio_level.sv
// audio path level block: apb registers, serial audio receiver, boost, fade, volume, mute
//
// Functional notes
// RULE1: boost field adds 0/6/12/18 dB, resets 01
// RULE2: speed bit 0 means single speed rates
// RULE3: speed bit 1 means double speed rates
// RULE4: format codes 000-011 select right-justified 24/20/18/16
// RULE5: format code 100 selects i2s, reset value
// RULE6: format code 101 selects left-justified 16-24 bits
// RULE7: host never writes reserved format codes above 101
// RULE8: fade bit enables fading, resets to one
// RULE9: right mute bit softly mutes right channel
// RULE10: left mute bit softly mutes left, mutes reset 0
// RULE11: config bits 6:2 read zero, host leaves them
// RULE12: code FF is +24 dB, FE +23.5 dB
// RULE13: code CF is 0 dB, level reset value
// RULE14: code 07 is the -100 dB floor
// RULE15: codes below 07 force the channel mute
// RULE16: left level code lives at index 04
// RULE17: right level at index 05, same encoding
// RULE18: fade and mutes live at index 03
// RULE19: each code step is 0.5 dB
// RULE20: with fade on, level ramps toward target
`timescale 1ns/1ps
module audio_level
  import audio_level_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial audio pins
  input wire serial_in_t ser,
  // processed samples
  output audio_out_t audio
);

  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // pin synchronisers; only the second stage is read
  serial_in_t sync1, sync2;
  logic sck_d;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sck_d <= 1'b0;
    end else begin
      sync1 <= ser;
      sync2 <= sync1;
      sck_d <= sync2.sck;
    end
  end

  logic sck_rise;
  assign sck_rise = sync2.sck & ~sck_d;

  // registers
  path_fmt_t fmt_reg, next_fmt;
  level_cfg_t cfg, next_cfg;
  logic [7:0] left_level, next_left_level;
  logic [7:0] right_level, next_right_level;
  logic [31:0] next_prdata, rd_val;
  logic next_pready, next_pslverr, mapped, wr;
  logic [7:0] idx;
  logic [1:0][7:0] cur_all;
  logic [1:0][23:0] gained;
  logic [1:0] muted;

  assign idx = paddr[9:2];
  assign wr = psel & penable & pready & pwrite & ~pslverr & pstrb[0];

  always_comb begin
    rd_val = 32'h0;
    mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    case (idx)
      FMT_IDX: rd_val = {26'h0, fmt_reg};
      CFG_IDX: rd_val = {24'h0, cfg.fade, 5'h00, cfg.mute_r, cfg.mute_l}; // [RULE11] [RULE18]
      LEFT_IDX: rd_val = {24'h0, left_level};
      RIGHT_IDX: rd_val = {24'h0, right_level};
      STAT_IDX: rd_val = {14'h0, muted, cur_all};
      default: mapped = 1'b0;
    endcase
    next_pready = psel & ~penable;
    next_pslverr = psel & ~penable & ~mapped;
    next_prdata = (psel & ~penable & ~pwrite & mapped) ? rd_val : 32'h0;
  end

  always_comb begin
    next_fmt = fmt_reg;
    next_cfg = cfg;
    next_left_level = left_level;
    next_right_level = right_level;
    if (wr) begin
      case (idx)
        FMT_IDX: next_fmt = path_fmt_t'(pwdata[FMT_W-1:0]); // [RULE1] [RULE2] [RULE3]
        CFG_IDX: next_cfg = '{fade: pwdata[FADE_BIT], mute_r: pwdata[MUTE_R_BIT],
                              mute_l: pwdata[MUTE_L_BIT]}; // [RULE8] [RULE18]
        LEFT_IDX: next_left_level = pwdata[7:0]; // [RULE16]
        RIGHT_IDX: next_right_level = pwdata[7:0]; // [RULE17]
        default: next_cfg = cfg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_reg <= FMT_RESET; // [RULE1] [RULE5]
      cfg <= CFG_RESET; // [RULE8] [RULE10]
      left_level <= LEVEL_RESET; // [RULE13]
      right_level <= LEVEL_RESET;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      fmt_reg <= next_fmt;
      cfg <= next_cfg;
      left_level <= next_left_level;
      right_level <= next_right_level;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // serial receiver: a word is handed on at each lrck change seen at a bit clock rise
  logic lr_d, next_lr_d;
  logic [31:0] shreg, next_shreg;
  logic [23:0] acc, next_acc, word, next_word;
  logic [4:0] cnt, next_cnt;
  logic word_left, next_word_left, emit, next_emit, is_lj, is_i2s;

  // reserved codes fall back to i2s framing; the host must not use them
  assign is_lj = (fmt_reg.fmt == FMT_LJ); // [RULE6]
  assign is_i2s = (fmt_reg.fmt > FMT_LJ) || (fmt_reg.fmt == FMT_I2S); // [RULE5] [RULE7]

  always_comb begin
    next_lr_d = lr_d;
    next_shreg = shreg;
    next_acc = acc;
    next_cnt = cnt;
    next_word = word;
    next_word_left = word_left;
    next_emit = 1'b0;
    if (sck_rise) begin
      next_lr_d = sync2.lrck;
      next_shreg = {shreg[30:0], sync2.sdin};
      if (sync2.lrck != lr_d) begin
        next_emit = 1'b1;
        next_word_left = is_i2s ? ~lr_d : lr_d; // [RULE5] [RULE6]
        case (fmt_reg.fmt)
          FMT_RJ24: next_word = shreg[23:0]; // [RULE4]
          FMT_RJ20: next_word = {{4{shreg[19]}}, shreg[19:0]};
          FMT_RJ18: next_word = {{6{shreg[17]}}, shreg[17:0]};
          FMT_RJ16: next_word = {{8{shreg[15]}}, shreg[15:0]};
          default: next_word = acc;
        endcase
        next_acc = 24'h0;
        // i2s drops the first bit clock after the edge, left-justified keeps it
        next_acc[SAMPLE_W-1] = is_lj & sync2.sdin;
        next_cnt = is_lj ? 5'h01 : 5'h00;
      end else if (cnt < WORD_BITS) begin
        next_acc[5'(SAMPLE_W - 1) - cnt] = sync2.sdin;
        next_cnt = cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lr_d <= 1'b0;
      shreg <= 32'h0;
      acc <= 24'h0;
      cnt <= 5'h00;
      word <= 24'h0;
      word_left <= 1'b0;
      emit <= 1'b0;
    end else begin
      lr_d <= next_lr_d;
      shreg <= next_shreg;
      acc <= next_acc;
      cnt <= next_cnt;
      word <= next_word;
      word_left <= next_word_left;
      emit <= next_emit;
    end
  end

  // fade pacing: one step per frame, every other frame at double speed so ramp time holds
  logic frame_end, fade_step, half_tgl, next_half_tgl;
  assign frame_end = emit & ~word_left;
  assign fade_step = frame_end & (~fmt_reg.speed | half_tgl); // [RULE2] [RULE3]
  assign next_half_tgl = frame_end ? ~half_tgl : half_tgl;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_tgl <= 1'b0;
    end else begin
      half_tgl <= next_half_tgl;
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [7:0] cur, next_cur, tgt, n, q;
    logic [3:0] r;
    logic signed [40:0] prod;
    logic signed [43:0] wide;

    always_comb begin
      tgt = (ch == 0) ? left_level : right_level;
      if ((ch == 0) ? cfg.mute_l : cfg.mute_r) begin
        tgt = LEVEL_OFF; // [RULE9] [RULE10]
      end
      next_cur = cur;
      if (!cfg.fade) begin
        next_cur = tgt; // [RULE8]
      end else if (fade_step && cur < tgt) begin
        next_cur = cur + 8'h01; // [RULE20]
      end else if (fade_step && cur > tgt) begin
        next_cur = cur - 8'h01; // [RULE20]
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cur <= LEVEL_RESET;
      end else begin
        cur <= next_cur;
      end
    end

    // gain = 16 * 2^(-n/12) * 2^boost, n half-dB steps below the top code
    always_comb begin
      n = LEVEL_TOP - cur; // [RULE12] [RULE19]
      q = n / STEPS_PER_6DB;
      r = 4'(n - 8'(q * STEPS_PER_6DB));
      prod = $signed(word) * $signed({1'b0, step_mant(r)});
      wide = 44'(prod) <<< fmt_reg.boost; // [RULE1]
      wide = wide >>> (GAIN_SHIFT + int'(q)); // [RULE13]
      if (wide > SAT_POS) begin
        gained[ch] = SAMPLE_MAX;
      end else if (wide < SAT_NEG) begin
        gained[ch] = SAMPLE_MIN;
      end else begin
        gained[ch] = wide[23:0];
      end
    end

    assign cur_all[ch] = cur;
    // below the floor the output holds midscale, i.e. 50/50 duty at the power stage
    assign muted[ch] = (cur < LEVEL_MIN); // [RULE14] [RULE15]
  end

  audio_out_t next_audio;

  always_comb begin
    next_audio = audio;
    next_audio.valid = frame_end;
    next_audio.mute_l = muted[0];
    next_audio.mute_r = muted[1];
    if (emit && word_left) begin
      next_audio.left = muted[0] ? 24'h0 : gained[0]; // [RULE10] [RULE15]
    end
    if (emit && !word_left) begin
      next_audio.right = muted[1] ? 24'h0 : gained[1]; // [RULE9] [RULE15]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      audio <= '0;
    end else begin
      audio <= next_audio;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic lr_edge;
  assign lr_edge = sck_rise & (sync2.lrck != lr_d);

  a_boost_write: assert property ( // [RULE1]
    wr && idx == FMT_IDX |=> fmt_reg.boost == $past(pwdata[5:4]))
    else $error("boost field not stored");
  a_single_ramp: assert property ( // [RULE2]
    cfg.fade && !fmt_reg.speed && frame_end && g_chan[0].cur < g_chan[0].tgt
    |=> g_chan[0].cur == $past(g_chan[0].cur) + 8'h01)
    else $error("single speed ramp step wrong");
  a_double_hold: assert property ( // [RULE3]
    cfg.fade && fmt_reg.speed && frame_end && !half_tgl |=> $stable(g_chan[0].cur))
    else $error("double speed stepped on skipped frame");
  a_rj16_word: assert property ( // [RULE4]
    lr_edge && fmt_reg.fmt == FMT_RJ16
    |=> word == {{8{$past(shreg[15])}}, $past(shreg[15:0])})
    else $error("right justified 16 bit word wrong");
  a_i2s_side: assert property ( // [RULE5]
    lr_edge && fmt_reg.fmt == FMT_I2S |=> emit && word_left == !$past(lr_d))
    else $error("i2s channel side wrong");
  a_lj_side: assert property ( // [RULE6]
    lr_edge && fmt_reg.fmt == FMT_LJ |=> emit && word_left == $past(lr_d))
    else $error("left justified channel side wrong");
  a_fade_off: assert property ( // [RULE8]
    !cfg.fade ##1 !cfg.fade |-> g_chan[0].cur == $past(g_chan[0].tgt))
    else $error("level did not jump with fade off");
  a_right_mute: assert property ( // [RULE9]
    emit && !word_left && muted[1] |=> audio.right == 24'h0 && audio.valid)
    else $error("muted right channel not silent");
  a_left_mute: assert property ( // [RULE10]
    emit && word_left && cfg.mute_l && !cfg.fade |-> ##2 audio.mute_l)
    else $error("left mute flag not raised");
  a_cfg_reserved: assert property ( // [RULE11]
    psel && !penable && !pwrite && idx == CFG_IDX |=> prdata[6:2] == 5'h00 && pready)
    else $error("reserved config bits not zero");
  a_unity_gain: assert property ( // [RULE13]
    g_chan[0].cur == LEVEL_RESET && fmt_reg.boost == 2'h0 |-> gained[0] == word)
    else $error("0 dB code not unity");
  a_floor_mute: assert property ( // [RULE15]
    g_chan[1].cur < LEVEL_MIN |-> muted[1] ##1 audio.mute_r)
    else $error("code below floor not muted");
  a_left_map: assert property ( // [RULE16]
    wr && idx == LEFT_IDX |=> left_level == $past(pwdata[7:0]))
    else $error("left level not stored");
  a_right_map: assert property ( // [RULE17]
    wr && idx == RIGHT_IDX |=> right_level == $past(pwdata[7:0]))
    else $error("right level not stored");
  a_cfg_map: assert property ( // [RULE18]
    wr && idx == CFG_IDX |=> {cfg.fade, cfg.mute_r, cfg.mute_l} == {$past(pwdata[7]), $past(pwdata[1]), $past(pwdata[0])})
    else $error("config bits not stored");
  a_fmt_store: assert property ( // [RULE4]
    wr && idx == FMT_IDX |=> {fmt_reg.speed, fmt_reg.fmt} == $past(pwdata[3:0]))
    else $error("format or speed not stored");
  a_top_gain: assert property ( // [RULE12]
    g_chan[0].cur == LEVEL_TOP && fmt_reg.boost == 2'h0 && word < 24'h080000
    |-> gained[0] == {word[19:0], 4'h0})
    else $error("top code not +24 dB");
  a_half_step: assert property ( // [RULE19]
    g_chan[1].cur == 8'hFE && fmt_reg.boost == 2'h0 && word == 24'h000800
    |-> gained[1] == 24'h0078D1)
    else $error("one code step not half a dB");
  a_floor_audible: assert property ( // [RULE14]
    g_chan[0].cur == LEVEL_MIN |-> !muted[0])
    else $error("floor code muted");
  a_fade_hold: assert property ( // [RULE20]
    cfg.fade && !fade_step |=> $stable(g_chan[0].cur))
    else $error("faded level moved between frames");
  a_left_silent: assert property ( // [RULE10]
    emit && word_left && muted[0] |=> audio.left == 24'h0)
    else $error("muted left channel not silent");

  c_i2s_frame: cover property (lr_edge && is_i2s ##[1:200] frame_end);
  c_fade_done: cover property (cfg.fade && g_chan[0].cur != g_chan[0].tgt
                               ##[1:1000] g_chan[0].cur == g_chan[0].tgt);
  c_soft_mute: cover property (cfg.mute_r && !muted[1] ##[1:1000] muted[1]);
  c_bus_error: cover property (pready && pslverr);
  c_double_fade: cover property (cfg.fade && fmt_reg.speed && fade_step);

endmodule : audio_level

// File: testbench/audio_src_model.sv
// serial audio source model driving the block's sample pins
`timescale 1ns/1ps
module audio_src_model
  import audio_level_pkg::*;
(
  // clock
  input wire logic clk,
  // sample pins
  output serial_in_t ser
);
  initial ser = '{sck: 1'b0, lrck: 1'b1, sdin: 1'b0};

  // one bit slot: data moves while sck is low, sampled on the rise
  task automatic slot(input logic lr, input logic d);
    ser.lrck <= lr;
    ser.sdin <= d;
    repeat (4) @(posedge clk);
    ser.sck <= 1'b1;
    repeat (4) @(posedge clk);
    ser.sck <= 1'b0;
  endtask : slot

  // n frames of 32-bit slots; sck stands still between calls
  task automatic play(input logic [2:0] f, input logic [23:0] l, input logic [23:0] r,
                      input int n);
    logic [23:0] w;
    logic b;
    int k;
    int j;
    k = (f == 3'h1) ? 20 : (f == 3'h2) ? 18 : (f == 3'h3) ? 16 : 24;
    b = 1'b0;
    @(posedge clk);
    repeat (n) begin
      for (int h = 0; h < 2; h++) begin
        w = h ? r : l;
        for (int i = 0; i < 32; i++) begin
          j = (f == 3'h4) ? i - 1 : (f == 3'h5) ? i : i - 32 + k;
          b = (j >= 0 && j < k) ? w[k-1-j] : i[0];
          slot((f == 3'h4) ? (h != 0) : (h == 0), b);
        end
      end
    end
    // a released line shows the inverse, never a held last bit
    ser.sdin <= ~b;
  endtask : play
endmodule : audio_src_model

// File: testbench/audio_level_tb.sv
// self-checking bench for the audio level block
`timescale 1ns/1ps
module audio_level_tb;
  import audio_level_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  serial_in_t ser;
  audio_out_t audio;
  int errors = 0;
  int total_checks = 0;
  int valids = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) if (audio.valid === 1'b1) valids <= valids + 1;

  audio_level u_audio_level (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ser(ser), .audio(audio));
  audio_src_model u_audio_src_model (.clk(clk), .ser(ser));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // setup and access; the request holds until pready is seen high or 50 access cycles pass
  task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(idx, 1'b1, d, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic eerr);
    logic [31:0] rd;
    logic err;
    apb(idx, 1'b0, 8'h00, rd, err);
    check(rd, exp);
    check({31'h0, err}, {31'h0, eerr});
  endtask : rd_chk

  task automatic out_chk(input logic [23:0] el, input logic [23:0] er, input logic ml,
                         input logic mr);
    check({audio.mute_l, audio.mute_r, 6'h0, audio.left}, {ml, mr, 6'h0, el});
    check({8'h0, audio.right}, {8'h0, er});
  endtask : out_chk

  task automatic t_reset();
    rd_chk(FMT_IDX, 32'h14, 1'b0);
    rd_chk(CFG_IDX, 32'h80, 1'b0);
    rd_chk(LEFT_IDX, 32'hCF, 1'b0);
    rd_chk(RIGHT_IDX, 32'hCF, 1'b0);
    rd_chk(STAT_IDX, 32'h0000CFCF, 1'b0);
    rd_chk(8'h07, 32'h0, 1'b1);
  endtask : t_reset

  task automatic t_regs();
    // reserved bits are left at zero by the host
    wr(CFG_IDX, 8'h83);
    rd_chk(CFG_IDX, 32'h83, 1'b0);
    wr(FMT_IDX, 8'h3D);
    rd_chk(FMT_IDX, 32'h3D, 1'b0);
    wr(LEFT_IDX, 8'h5A);
    wr(RIGHT_IDX, 8'hA5);
    pstrb <= 4'h0;
    wr(LEFT_IDX, 8'h11);
    pstrb <= 4'hF;
    rd_chk(LEFT_IDX, 32'h5A, 1'b0);
    rd_chk(RIGHT_IDX, 32'hA5, 1'b0);
    wr(CFG_IDX, 8'h00);
    wr(LEFT_IDX, 8'hCF);
    wr(RIGHT_IDX, 8'hCF);
  endtask : t_regs

  task automatic t_formats();
    logic [23:0] wl [6] = '{24'h812345, 24'h081234, 24'h021234, 24'h008123, 24'h654321,
                            24'h123456};
    logic [23:0] el [6] = '{24'h812345, 24'hF81234, 24'hFE1234, 24'hFF8123, 24'h654321,
                            24'h123456};
    // codes 6 and 7 are never written
    for (int f = 0; f < 6; f++) begin
      wr(FMT_IDX, {5'h00, 3'(f)});
      valids = 0;
      u_audio_src_model.play(3'(f), wl[f], 24'h001234, 3);
      out_chk(el[f], 24'h001234, 1'b0, 1'b0);
      check(32'(valids >= 2), 32'h1);
    end
  endtask : t_formats

  task automatic t_gain();
    logic [7:0] fr [8] = '{8'h04, 8'h14, 8'h24, 8'h34, 8'h0C, 8'h04, 8'h04, 8'h04};
    logic [7:0] cd [8] = '{8'hCF, 8'hCF, 8'hCF, 8'hCF, 8'hCF, 8'hFF, 8'hFE, 8'hC3};
    logic [23:0] wd [8] = '{24'h100000, 24'h100000, 24'h100000, 24'h100000, 24'h100000,
                            24'h000100, 24'h000800, 24'h001000};
    logic [23:0] ex [8] = '{24'h100000, 24'h200000, 24'h400000, 24'h7FFFFF, 24'h100000,
                            24'h001000, 24'h0078D1, 24'h000800};
    for (int g = 0; g < 8; g++) begin
      wr(FMT_IDX, fr[g]);
      wr(LEFT_IDX, cd[g]);
      wr(RIGHT_IDX, cd[g]);
      u_audio_src_model.play(3'h4, wd[g], wd[g], 3);
      out_chk(ex[g], ex[g], 1'b0, 1'b0);
    end
  endtask : t_gain

  task automatic t_mute();
    wr(FMT_IDX, 8'h04);
    wr(LEFT_IDX, 8'hCF);
    wr(RIGHT_IDX, 8'hCF);
    wr(CFG_IDX, 8'h01);
    u_audio_src_model.play(3'h4, 24'h100000, 24'h100000, 3);
    out_chk(24'h0, 24'h100000, 1'b1, 1'b0);
    wr(CFG_IDX, 8'h02);
    u_audio_src_model.play(3'h4, 24'h100000, 24'h100000, 3);
    out_chk(24'h100000, 24'h0, 1'b0, 1'b1);
    wr(CFG_IDX, 8'h00);
    wr(LEFT_IDX, 8'h06);
    u_audio_src_model.play(3'h4, 24'h100000, 24'h100000, 3);
    out_chk(24'h0, 24'h100000, 1'b1, 1'b0);
    wr(LEFT_IDX, 8'h07);
    rd_chk(STAT_IDX, 32'h0000CF07, 1'b0);
    check({31'h0, audio.mute_l}, 32'h0);
  endtask : t_mute

  // ramp steps once per frame, so the frame count fixes the expected code
  task automatic t_fade();
    wr(LEFT_IDX, 8'hCF);
    wr(CFG_IDX, 8'h80);
    wr(LEFT_IDX, 8'hD3);
    rd_chk(STAT_IDX, 32'h0000CFCF, 1'b0);
    u_audio_src_model.play(3'h4, 24'h100000, 24'h100000, 1);
    rd_chk(STAT_IDX, 32'h0000CFD0, 1'b0);
    u_audio_src_model.play(3'h4, 24'h100000, 24'h100000, 3);
    rd_chk(STAT_IDX, 32'h0000CFD3, 1'b0);
    wr(CFG_IDX, 8'h00);
    wr(LEFT_IDX, 8'hCF);
    rd_chk(STAT_IDX, 32'h0000CFCF, 1'b0);
    // double speed: four frame ends give two steps, whatever the pacing phase
    wr(FMT_IDX, 8'h0C);
    wr(CFG_IDX, 8'h80);
    wr(LEFT_IDX, 8'hD3);
    u_audio_src_model.play(3'h4, 24'h100000, 24'h100000, 4);
    rd_chk(STAT_IDX, 32'h0000CFD1, 1'b0);
  endtask : t_fade

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_regs();
    t_formats();
    t_gain();
    t_mute();
    t_fade();
    summarize();
  end

  // about 30k cycles are needed; reaching 80k means a hang
  initial begin
    #2000000;
    errors++;
    summarize();
  end
endmodule : audio_level_tb
